// ### rtl/rbr_pkg.sv
// Package for the radio buffer, amplifier and interrupt mask register bank.
// Assumes an eight-bit register port fed by the serial interface engine.
package rbr_pkg;
    // Register byte addresses
    localparam logic [7:0] RBR_ADDR_AMP = 8'h0c;
    localparam logic [7:0] RBR_ADDR_PTR = 8'h0d;
    localparam logic [7:0] RBR_ADDR_TXBASE = 8'h0e;
    localparam logic [7:0] RBR_ADDR_RXBASE = 8'h0f;
    localparam logic [7:0] RBR_ADDR_RXSTART = 8'h10;
    localparam logic [7:0] RBR_ADDR_MASK = 8'h11;
    localparam logic [7:0] RBR_ADDR_FLAGS = 8'h12;

    // Reset values
    localparam logic [7:0] RBR_RST_AMP = 8'h20;
    localparam logic [7:0] RBR_RST_PTR = 8'h00;
    localparam logic [7:0] RBR_RST_TXBASE = 8'h80;
    localparam logic [7:0] RBR_RST_RXBASE = 8'h00;
    localparam logic [7:0] RBR_RST_RXSTART = 8'h00;
    localparam logic [7:0] RBR_RST_MASK = 8'h00;
    localparam logic [7:0] RBR_RST_FLAGS = 8'h00;
    localparam logic [7:0] RBR_READ_ZERO = 8'h00;

    // Gain select, high-band boost and pointer step codes
    localparam logic [2:0] RBR_GAIN_UNUSED_LO = 3'h0;
    localparam logic [2:0] RBR_GAIN_UNUSED_HI = 3'h7;
    localparam logic [1:0] RBR_HF_BOOST_ON = 2'h3;
    localparam logic [7:0] RBR_PTR_STEP = 8'h01;

    // Interrupt bit positions, shared by flag and mask registers
    localparam int RBR_IRQ_RX_TIMEOUT = 7;
    localparam int RBR_IRQ_RX_DONE = 6;
    localparam int RBR_IRQ_CRC_FAIL = 5;
    localparam int RBR_IRQ_HDR_OK = 4;
    localparam int RBR_IRQ_TX_DONE = 3;
    localparam int RBR_IRQ_SCAN_DONE = 2;
    localparam int RBR_IRQ_HOP = 1;
    localparam int RBR_IRQ_FOUND = 0;

    // Receive amplifier configuration layout
    typedef struct packed {
        logic [2:0] rx_amp_gain_sel;
        logic [1:0] lowband_amp_current;
        logic reserved_bit;
        logic [1:0] highband_amp_boost;
    } rbr_amp_cfg_t;

    // Buffer pointer set
    typedef struct packed {
        logic [7:0] buffer_access_ptr;
        logic [7:0] tx_buffer_base_addr;
        logic [7:0] rx_buffer_base_addr;
        logic [7:0] last_rx_packet_start_addr;
    } rbr_buf_ptrs_t;
endpackage

// ### rtl/rbr_regs.sv
// Amplifier, packet buffer pointer and interrupt mask register bank.
// Assumes a register port from the serial engine, synchronous to MCLK_IN,
// and one-cycle event pulses from the modem.
//
// How it works
// - Gain field 7..5: 001 max to 110 min
// - High-band code 11 turns on boost
// - Eight-bit buffer access pointer, resets zero
// - Transmit base address, read/write, resets 0x80
// - Receive base address, read/write, resets zero
// - Read-only start of last received packet
// - Mask bit one suppresses its interrupt
// - Upper mask bits: timeout, done, check, header
// - Lower mask bits: tx done, scan, hop, found
// - Host write clears serviced interrupt flags
`timescale 1ns/1ps
`default_nettype none

module rbr_regs (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    // Register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    // Modem side
    input wire logic BUF_ACCESS_IN,
    input wire logic RX_START_LOAD_IN,
    input wire logic [7:0] RX_START_ADDR_IN,
    input wire logic [7:0] IRQ_EVENT_IN,
    // Configuration and status
    output rbr_pkg::rbr_amp_cfg_t AMP_CFG_OUT,
    output logic HF_BOOST_OUT,
    output rbr_pkg::rbr_buf_ptrs_t BUF_PTRS_OUT,
    output logic [7:0] IRQ_FLAGS_OUT,
    output logic IRQ_OUT
);

    rbr_pkg::rbr_amp_cfg_t amp_q;
    rbr_pkg::rbr_amp_cfg_t amp_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] txbase_q;
    logic [7:0] rxbase_q;
    logic [7:0] rxstart_q;
    logic [7:0] mask_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_amp = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_AMP);
    wire wr_ptr = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_PTR);
    wire wr_txbase = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_TXBASE);
    wire wr_rxbase = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_RXBASE);
    wire wr_mask = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_MASK);
    wire wr_flags = REG_WR_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_FLAGS);

    ////////////////////////////////////////////////////////////////////////
    // Amplifier field update
    // Write byte seen through the register layout, so no field position is hand-coded
    rbr_pkg::rbr_amp_cfg_t amp_wr;
    assign amp_wr = REG_WDATA_IN;
    wire [2:0] gain_wr = amp_wr.rx_amp_gain_sel;
    // Unused gain codes keep the last legal step, so gain is never undefined
    wire gain_legal = (gain_wr != rbr_pkg::RBR_GAIN_UNUSED_LO)
                   && (gain_wr != rbr_pkg::RBR_GAIN_UNUSED_HI);
    assign amp_d = wr_amp ? {(gain_legal ? gain_wr : amp_q.rx_amp_gain_sel),
                             amp_wr.lowband_amp_current,
                             amp_wr.reserved_bit,
                             amp_wr.highband_amp_boost} : amp_q;

    // Pointer: host write wins over a buffer access step in the same cycle
    assign ptr_d = wr_ptr ? REG_WDATA_IN :
                   BUF_ACCESS_IN ? ptr_q + rbr_pkg::RBR_PTR_STEP : ptr_q;

    // Flags: a new event wins over a host clear in the same cycle
    assign flags_d = (flags_q & ~(wr_flags ? REG_WDATA_IN : rbr_pkg::RBR_READ_ZERO))
                   | IRQ_EVENT_IN;

    ////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped addresses read zero
    always_comb begin
        case (REG_ADDR_IN)
            rbr_pkg::RBR_ADDR_AMP: rdata_d = amp_q;
            rbr_pkg::RBR_ADDR_PTR: rdata_d = ptr_q;
            rbr_pkg::RBR_ADDR_TXBASE: rdata_d = txbase_q;
            rbr_pkg::RBR_ADDR_RXBASE: rdata_d = rxbase_q;
            rbr_pkg::RBR_ADDR_RXSTART: rdata_d = rxstart_q;
            rbr_pkg::RBR_ADDR_MASK: rdata_d = mask_q;
            rbr_pkg::RBR_ADDR_FLAGS: rdata_d = flags_q;
            default: rdata_d = rbr_pkg::RBR_READ_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            amp_q <= rbr_pkg::RBR_RST_AMP;
            ptr_q <= rbr_pkg::RBR_RST_PTR;
            txbase_q <= rbr_pkg::RBR_RST_TXBASE;
            rxbase_q <= rbr_pkg::RBR_RST_RXBASE;
            rxstart_q <= rbr_pkg::RBR_RST_RXSTART;
            mask_q <= rbr_pkg::RBR_RST_MASK;
            flags_q <= rbr_pkg::RBR_RST_FLAGS;
        end else begin
            amp_q <= amp_d;
            ptr_q <= ptr_d;
            txbase_q <= wr_txbase ? REG_WDATA_IN : txbase_q;
            rxbase_q <= wr_rxbase ? REG_WDATA_IN : rxbase_q;
            // Only the modem loads it; host writes are ignored
            rxstart_q <= RX_START_LOAD_IN ? RX_START_ADDR_IN : rxstart_q;
            mask_q <= wr_mask ? REG_WDATA_IN : mask_q;
            flags_q <= flags_d;
        end
    end

    // Read data register, valid the cycle after the read strobe
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            rdata_q <= rbr_pkg::RBR_READ_ZERO;
        end else if (REG_RD_IN) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign REG_RDATA_OUT = rdata_q;
    // Low-band current is passed as written; host must keep it at 00
    assign AMP_CFG_OUT = amp_q;
    assign HF_BOOST_OUT = (amp_q.highband_amp_boost == rbr_pkg::RBR_HF_BOOST_ON);
    assign BUF_PTRS_OUT = {ptr_q, txbase_q, rxbase_q, rxstart_q};
    assign IRQ_FLAGS_OUT = flags_q;
    // Masked flags still latch, they just stay off the interrupt line
    assign IRQ_OUT = |(flags_q & ~mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_gain_legal_only: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        (amp_q.rx_amp_gain_sel != rbr_pkg::RBR_GAIN_UNUSED_LO)
        && (amp_q.rx_amp_gain_sel != rbr_pkg::RBR_GAIN_UNUSED_HI))
        else $error("gain select holds an unused code");
    chk_hf_boost_map: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        HF_BOOST_OUT == (AMP_CFG_OUT.highband_amp_boost == rbr_pkg::RBR_HF_BOOST_ON))
        else $error("boost output does not follow code 11");
    chk_ptr_step: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        BUF_ACCESS_IN && !wr_ptr
        |=> BUF_PTRS_OUT.buffer_access_ptr == $past(ptr_q) + rbr_pkg::RBR_PTR_STEP)
        else $error("pointer did not advance on buffer access");
    chk_txbase_reset: assert property (@(posedge MCLK_IN)
        !RST_N_IN |=> BUF_PTRS_OUT.tx_buffer_base_addr == rbr_pkg::RBR_RST_TXBASE)
        else $error("transmit base not 0x80 after reset");
    chk_rxbase_write: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_rxbase |=> BUF_PTRS_OUT.rx_buffer_base_addr == $past(REG_WDATA_IN))
        else $error("receive base write lost");
    chk_rxstart_ro: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        !RX_START_LOAD_IN |=> $stable(BUF_PTRS_OUT.last_rx_packet_start_addr))
        else $error("packet start changed without modem load");
    chk_mask_reset: assert property (@(posedge MCLK_IN)
        !RST_N_IN |=> mask_q == rbr_pkg::RBR_RST_MASK && !IRQ_OUT)
        else $error("mask not cleared by reset");
    chk_timeout_bit: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        IRQ_EVENT_IN[rbr_pkg::RBR_IRQ_RX_TIMEOUT] && mask_q[rbr_pkg::RBR_IRQ_RX_TIMEOUT]
        && ((IRQ_EVENT_IN & ~mask_q) == rbr_pkg::RBR_READ_ZERO)
        && (flags_q == rbr_pkg::RBR_RST_FLAGS) && !wr_mask |=> !IRQ_OUT)
        else $error("masked timeout raised interrupt");
    chk_found_bit: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        IRQ_EVENT_IN[rbr_pkg::RBR_IRQ_FOUND] && !wr_mask ##1 !mask_q[rbr_pkg::RBR_IRQ_FOUND]
        |-> IRQ_OUT && IRQ_FLAGS_OUT[rbr_pkg::RBR_IRQ_FOUND])
        else $error("unmasked detect flag did not interrupt");
    chk_flag_clear: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_flags && REG_WDATA_IN[rbr_pkg::RBR_IRQ_TX_DONE]
        && !IRQ_EVENT_IN[rbr_pkg::RBR_IRQ_TX_DONE] |=> !IRQ_FLAGS_OUT[rbr_pkg::RBR_IRQ_TX_DONE])
        else $error("flag not cleared by host write");
    chk_event_wins: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_flags && IRQ_EVENT_IN[rbr_pkg::RBR_IRQ_RX_DONE]
        |=> IRQ_FLAGS_OUT[rbr_pkg::RBR_IRQ_RX_DONE])
        else $error("event lost against clear");
    chk_irq_all_masked: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        ((IRQ_FLAGS_OUT & ~mask_q) == rbr_pkg::RBR_READ_ZERO) == !IRQ_OUT)
        else $error("interrupt output disagrees with flags and mask");

    // Write and load paths: each byte lands one cycle after its strobe, except an unused gain code; flags hold without a clear
    chk_ptr_host_wins: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_ptr |=> BUF_PTRS_OUT.buffer_access_ptr == $past(REG_WDATA_IN))
        else $error("host pointer write lost");
    chk_txbase_write: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_txbase |=> BUF_PTRS_OUT.tx_buffer_base_addr == $past(REG_WDATA_IN))
        else $error("transmit base write lost");
    chk_mask_write: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_mask |=> mask_q == $past(REG_WDATA_IN))
        else $error("mask write lost");
    chk_gain_taken: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_amp && gain_legal |=> AMP_CFG_OUT.rx_amp_gain_sel == $past(gain_wr))
        else $error("legal gain code not taken");
    chk_gain_kept: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        wr_amp && !gain_legal |=> $stable(AMP_CFG_OUT.rx_amp_gain_sel))
        else $error("unused gain code changed the gain");
    chk_rxstart_load: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        RX_START_LOAD_IN
        |=> BUF_PTRS_OUT.last_rx_packet_start_addr == $past(RX_START_ADDR_IN))
        else $error("packet start not loaded from modem");
    chk_flag_sticky: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        !wr_flags |=> (IRQ_FLAGS_OUT & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without a host clear");

    // Read data and reset values, seen from the pins
    chk_rdata_rxstart: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        REG_RD_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_RXSTART)
        |=> REG_RDATA_OUT == $past(rxstart_q))
        else $error("packet start read back wrong");
    chk_rdata_mask: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
        REG_RD_IN && (REG_ADDR_IN == rbr_pkg::RBR_ADDR_MASK)
        |=> REG_RDATA_OUT == $past(mask_q))
        else $error("mask read back wrong");
    chk_amp_reset: assert property (@(posedge MCLK_IN)
        !RST_N_IN |=> AMP_CFG_OUT == rbr_pkg::RBR_RST_AMP)
        else $error("amplifier config not at reset value");
    chk_ptr_rx_reset: assert property (@(posedge MCLK_IN)
        !RST_N_IN |=> BUF_PTRS_OUT.buffer_access_ptr == rbr_pkg::RBR_RST_PTR
            && BUF_PTRS_OUT.rx_buffer_base_addr == rbr_pkg::RBR_RST_RXBASE)
        else $error("pointer or receive base not zero after reset");
    chk_flags_reset: assert property (@(posedge MCLK_IN)
        !RST_N_IN |=> IRQ_FLAGS_OUT == rbr_pkg::RBR_RST_FLAGS)
        else $error("flags not cleared by reset");

endmodule // rbr_regs

`default_nettype wire

// ### dv/rbr_host_model.sv
// Host model: a microcontroller driving the register strobe port.
// Assumes strobes and address are sampled on the rising edge of CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module rbr_host_model (
    // Clock
    input wire logic CLK_IN,
    // Register port
    output logic [7:0] ADDR_OUT,
    output logic WR_OUT,
    output logic RD_OUT,
    output logic [7:0] WDATA_OUT,
    input wire logic [7:0] RDATA_IN
);
    // Idle bus from time zero
    initial begin
        ADDR_OUT = 8'h00;
        WR_OUT = 1'b0;
        RD_OUT = 1'b0;
        WDATA_OUT = 8'h00;
    end
    // One write; data inverted after release so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        ADDR_OUT <= a;
        WDATA_OUT <= d;
        WR_OUT <= 1'b1;
        @(posedge CLK_IN);
        WR_OUT <= 1'b0;
        WDATA_OUT <= ~d;
    endtask
    // One read; data lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK_IN);
        ADDR_OUT <= a;
        RD_OUT <= 1'b1;
        @(posedge CLK_IN);
        RD_OUT <= 1'b0;
        #1 d = RDATA_IN;
    endtask
endmodule // rbr_host_model
`default_nettype wire

// ### dv/radio_buffer_irq_mask_regs_tb.sv
// Self-checking bench for the amplifier, pointer and mask register bank.
// Assumes rbr_regs and the host model; modem pulses driven here.
`timescale 1ns/1ps
`default_nettype none
module radio_buffer_irq_mask_regs_tb;
    typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} rbr_row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic acc = 1'b0;
    logic ld = 1'b0;
    logic [7:0] ld_addr = 8'h00;
    logic [7:0] evt = 8'h00;
    logic [7:0] addr, wdata, rdata, flags, got;
    logic wr, rd, hf, irq;
    rbr_pkg::rbr_amp_cfg_t amp;
    rbr_pkg::rbr_buf_ptrs_t ptrs;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Reset reads first, then writes; gain codes 000 and 111 keep the old gain
    rbr_row_t rows [0:17] = '{'{8'h0c,0,0,8'h20}, '{8'h0d,0,0,0}, '{8'h0e,0,0,8'h80},
        '{8'h0f,0,0,0}, '{8'h10,0,0,0}, '{8'h11,0,0,0}, '{8'h12,0,0,0},
        '{8'h0d,1,8'h5a,8'h5a}, '{8'h0e,1,8'h33,8'h33}, '{8'h0f,1,8'hc4,8'hc4},
        '{8'h11,1,8'hf0,8'hf0}, '{8'h11,1,8'h0f,8'h0f}, '{8'h0c,1,8'h23,8'h23},
        '{8'h0c,1,8'hc0,8'hc0}, '{8'h0c,1,8'h03,8'hc3}, '{8'h0c,1,8'he0,8'hc0},
        '{8'h10,1,8'h77,8'h00}, '{8'h13,1,8'h55,8'h00}};
    ////////////////////////////////////////////////////////////////////////
    always #50 mclk = ~mclk;
    rbr_regs dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .BUF_ACCESS_IN(acc),
        .RX_START_LOAD_IN(ld), .RX_START_ADDR_IN(ld_addr), .IRQ_EVENT_IN(evt),
        .AMP_CFG_OUT(amp), .HF_BOOST_OUT(hf), .BUF_PTRS_OUT(ptrs), .IRQ_FLAGS_OUT(flags),
        .IRQ_OUT(irq));
    rbr_host_model host (.CLK_IN(mclk), .ADDR_OUT(addr), .WR_OUT(wr), .RD_OUT(rd),
        .WDATA_OUT(wdata), .RDATA_IN(rdata));
    // Compare one byte
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One-cycle event pulse, flags settled afterwards
    task automatic pulse_evt(input logic [7:0] e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= 8'h00;
        #1;
    endtask
    // Hang guard, well above the roughly 150 cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, got);
            chk(got, rows[i].e, "readback");
        end
        host.wr(8'h0c, 8'h23);
        #1 chk({7'h00, hf}, 8'h01, "boost");
        chk({5'h00, amp.rx_amp_gain_sel}, 8'h01, "gain");
        host.wr(8'h0d, 8'hff);
        @(posedge mclk);
        acc <= 1'b1;
        @(posedge mclk);
        acc <= 1'b0;
        #1 chk(ptrs.buffer_access_ptr, 8'h00, "wrap");
        @(posedge mclk);
        ld_addr <= 8'h9c;
        ld <= 1'b1;
        @(posedge mclk);
        ld <= 1'b0;
        host.rd(8'h10, got);
        chk(got, 8'h9c, "rx start");
        // Each bit alone unmasked: others must stay silent
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h11, ~(8'h01 << i));
            pulse_evt(~(8'h01 << i));
            chk({7'h00, irq}, 8'h00, "masked");
            chk(flags, ~(8'h01 << i), "flags");
            pulse_evt(8'h01 << i);
            chk({7'h00, irq}, 8'h01, "unmasked");
            host.wr(8'h12, 8'hff);
            #1 chk(flags, 8'h00, "clear");
        end
        // Host pointer write and buffer step on one edge: the write wins
        fork
            host.wr(8'h0d, 8'h42);
            begin
                @(posedge mclk);
                acc <= 1'b1;
                @(posedge mclk);
                acc <= 1'b0;
            end
        join
        #1 chk(ptrs.buffer_access_ptr, 8'h42, "ptr collision");
        // Event and host clear on one edge: the event survives
        host.wr(8'h11, 8'h00);
        fork
            host.wr(8'h12, 8'hff);
            pulse_evt(8'h40);
        join
        chk(flags, 8'h40, "event wins");
        chk({7'h00, irq}, 8'h01, "event irq");
        // Mid-run reset with every register dirty
        host.wr(8'h11, 8'haa);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk(amp, 8'h20, "amp reset");
        chk({7'h00, hf}, 8'h00, "boost reset");
        chk(ptrs.buffer_access_ptr, 8'h00, "ptr reset");
        chk(ptrs.tx_buffer_base_addr, 8'h80, "tx base reset");
        chk(ptrs.rx_buffer_base_addr, 8'h00, "rx base reset");
        chk(ptrs.last_rx_packet_start_addr, 8'h00, "rx start reset");
        chk(flags, 8'h00, "flags reset");
        chk({7'h00, irq}, 8'h00, "irq reset");
        host.rd(8'h11, got);
        chk(got, 8'h00, "mask reset");
        tally_and_finish();
    end
endmodule // radio_buffer_irq_mask_regs_tb
`default_nettype wire
